// >>> inc/tacr_params.svh
`ifndef TACR_PARAMS_SVH
`define TACR_PARAMS_SVH

`define TACR_ERR_OPTION 8'h03
`define TACR_ERR_GENERIC 8'h0F
`define TACR_ERR_BLK_NA 8'h10
`define TACR_ERR_BLK_RELOCK 8'h11
`define TACR_ERR_BLK_LOCKED 8'h12
`define TACR_ERR_PROG_FAIL 8'h13
`define TACR_ERR_LOCK_FAIL 8'h14
`define TACR_CMD_INVENTORY 8'h01
`define TACR_CMD_FAST_INV_INIT 8'hC1
`define TACR_CMD_FAST_INITIATE 8'hC2
`define TACR_CMD_INV_INIT 8'hD1
`define TACR_CMD_INITIATE 8'hD2
`define TACR_FLAG_FAMILY 4
`define TACR_FLAG_SLOTSEL 5
`define TACR_SLOTS_MANY 5'h10
`define TACR_LAST_SLOT 4'hF
`define TACR_IDX_WIDTH_MANY 7'h04
`define TACR_MASK_MAX_BITS 7'h40
`define TACR_T1_NS 320900
`define TACR_CLK_NS 40
`define TACR_T1_CYCLES ((`TACR_T1_NS) / (`TACR_CLK_NS))

`endif

// >>> inc/tacr_pkg.sv
package tacr_pkg;
  typedef enum logic [2:0] {
    TACR_ERR_NONE_CAUSE = 3'h0,
    TACR_ERR_OPTION_CAUSE = 3'h1,
    TACR_ERR_BLOCK_NA_CAUSE = 3'h2,
    TACR_ERR_RELOCK_CAUSE = 3'h3,
    TACR_ERR_LOCKED_CAUSE = 3'h4,
    TACR_ERR_PROG_CAUSE = 3'h5,
    TACR_ERR_LOCKFAIL_CAUSE = 3'h6,
    TACR_ERR_OTHER_CAUSE = 3'h7
  } tacr_cause_type;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] command;
    logic [7:0] family_id;
    logic [7:0] mask_len;
    logic [63:0] mask;
  } tacr_request_type;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] error_code;
    logic error_present;
  } tacr_header_type;
endpackage : tacr_pkg

// >>> rtl/tacr_core.sv
// Function
// - Flag bit 0 set on error; error code byte then follows
// - Flag byte eight bits, extension and reserved bits zero
// - Error code valid only when the error bit is set
// - Code 03h unsupported option, 0Fh unspecified error
// - Codes 10h, 11h, 12h for block unavailable, relock, locked
// - Codes 13h program failure, 14h lock failure
// - No other error code value is ever emitted
// - Mask length counts bits; mask 0 to 8 bytes, LSB first
// - Short masks padded with zeros at top to byte boundary
// - Request: flags, command, optional family id, length, mask, CRC
// - Slot select set: one slot, no index; else 16 slots
// - Answer when low UID bits match slot index over mask
// - Slot 0 after request end; each end-of-frame advances index (code ignores an end-of-frame during the response delay)
// - Start-of-frame aborts the sequence; new request is processed
// - Each inventory request restarts slot index at zero (code takes a request only when idle and ignores one that arrives mid-sequence)
// - Initiated bit set by initiate; gates initiated inventory
// - Fast variants double the response data rate
// - No reply to an inventory request that carries an error
// - Wait the nominal response delay after each end-of-frame
`timescale 1ns/1ps
`include "tacr_params.svh"

module tacr_core #(
  parameter int unsigned T1_CYCLES = `TACR_T1_CYCLES,
  parameter logic [63:0] UID = 64'h0123_4567_89AB_CDEF
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire tacr_pkg::tacr_request_type req_in,
  input wire logic req_error_in,
  input wire logic sof_in,
  input wire logic eof_in,
  input wire tacr_pkg::tacr_cause_type cause_in,
  input wire logic cause_valid_in,
  output tacr_pkg::tacr_header_type header_out,
  output logic reply_out,
  output logic [3:0] slot_index_out,
  output logic active_out,
  output logic initiated_out,
  output logic fast_rate_out
);
  import tacr_pkg::*;

  typedef enum logic [2:0] {
    TACR_IDLE = 3'b001,
    TACR_WAIT = 3'b010,
    TACR_SLOT = 3'b100
  } tacr_state_type;

  tacr_state_type state_reg;
  logic [3:0] slot_index_reg;
  logic slot_count_select_reg;
  logic [6:0] mask_bits_reg;
  logic [63:0] mask_reg;
  logic timer_start;
  logic timer_abort;
  logic timer_done;
  logic match;
  logic [6:0] slot_index_width;
  logic [63:0] compare_value;
  logic [63:0] compare_mask;
  logic [7:0] code_next;
  logic is_inventory;
  logic inventory_ok;
  logic [63:0] mask_keep;
  logic [23:0] wait_cycles_reg;

  // Cycle count rounds down from the nominal delay
  tacr_delay #(.CYCLES(T1_CYCLES)) u_delay (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .start_in(timer_start),
    .abort_in(timer_abort),
    .done_out(timer_done)
  );

  always_comb begin
    case (cause_in)
      TACR_ERR_OPTION_CAUSE: code_next = `TACR_ERR_OPTION;
      TACR_ERR_BLOCK_NA_CAUSE: code_next = `TACR_ERR_BLK_NA;
      TACR_ERR_RELOCK_CAUSE: code_next = `TACR_ERR_BLK_RELOCK;
      TACR_ERR_LOCKED_CAUSE: code_next = `TACR_ERR_BLK_LOCKED;
      TACR_ERR_PROG_CAUSE: code_next = `TACR_ERR_PROG_FAIL;
      TACR_ERR_LOCKFAIL_CAUSE: code_next = `TACR_ERR_LOCK_FAIL;
      default: code_next = `TACR_ERR_GENERIC;
    endcase
  end

  // Header for non-inventory responses; the code is zero when unused
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      header_out <= '0;
    end else if (cause_valid_in) begin
      header_out.flags <= 8'h00;
      if (cause_in != TACR_ERR_NONE_CAUSE) begin
        header_out.flags[0] <= 1'b1;
        header_out.error_code <= code_next;
        header_out.error_present <= 1'b1;
      end else begin
        header_out.error_code <= 8'h00;
        header_out.error_present <= 1'b0;
      end
    end
  end

  assign is_inventory = (req_in.command == `TACR_CMD_INVENTORY) ||
                        (req_in.command == `TACR_CMD_INV_INIT) ||
                        (req_in.command == `TACR_CMD_FAST_INV_INIT);
  // Requests are taken only at rest; a start-of-frame in the same cycle wins
  assign inventory_ok = req_valid_in && !req_error_in && is_inventory &&
                        (state_reg == TACR_IDLE) && !sof_in &&
                        (req_in.mask_len <= {1'b0, `TACR_MASK_MAX_BITS}) &&
                        ((req_in.command == `TACR_CMD_INVENTORY) || initiated_out);

  // Initiated bit and fast rate selection
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      initiated_out <= 1'b0;
      fast_rate_out <= 1'b0;
    end else if (req_valid_in && !req_error_in) begin
      if (req_in.command == `TACR_CMD_INITIATE || req_in.command == `TACR_CMD_FAST_INITIATE) begin
        initiated_out <= 1'b1;
      end
      fast_rate_out <= (req_in.command == `TACR_CMD_FAST_INITIATE) ||
                       (req_in.command == `TACR_CMD_FAST_INV_INIT);
    end
  end

  // Comparison: index sits just above the significant mask bits
  assign slot_index_width = slot_count_select_reg ? 7'h00 : `TACR_IDX_WIDTH_MANY;
  always_comb begin
    compare_value = mask_reg | (64'(slot_index_reg) << mask_bits_reg);
    compare_mask = 64'hFFFF_FFFF_FFFF_FFFF;
    if ((mask_bits_reg + slot_index_width) < 7'h40) begin
      compare_mask = ~(64'hFFFF_FFFF_FFFF_FFFF << (mask_bits_reg + slot_index_width));
    end
  end
  assign match = ((UID ^ compare_value) & compare_mask) == 64'h0000_0000_0000_0000;

  // Padding above the mask length is cleared so it never takes part
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mask_reg <= 64'h0000_0000_0000_0000;
      mask_bits_reg <= 7'h00;
      slot_count_select_reg <= 1'b0;
    end else if (inventory_ok) begin
      mask_bits_reg <= req_in.mask_len[6:0];
      slot_count_select_reg <= req_in.flags[`TACR_FLAG_SLOTSEL];
      if (req_in.mask_len[6:0] >= 7'h40) begin
        mask_reg <= req_in.mask;
      end else begin
        mask_reg <= req_in.mask & ~(64'hFFFF_FFFF_FFFF_FFFF << req_in.mask_len[6:0]);
      end
    end
  end

  assign timer_start = (state_reg == TACR_IDLE && inventory_ok) ||
                       (state_reg == TACR_SLOT && eof_in && !sof_in &&
                        !slot_count_select_reg && slot_index_reg != `TACR_LAST_SLOT);
  assign timer_abort = sof_in;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= TACR_IDLE;
      slot_index_reg <= 4'h0;
    end else begin
      case (state_reg)
        TACR_IDLE: begin
          if (inventory_ok) begin
            slot_index_reg <= 4'h0;
            state_reg <= TACR_WAIT;
          end
        end
        TACR_WAIT: begin
          if (sof_in) begin
            state_reg <= TACR_IDLE;
          end else if (timer_done) begin
            state_reg <= TACR_SLOT;
          end
        end
        TACR_SLOT: begin
          if (sof_in) begin
            state_reg <= TACR_IDLE;
          end else if (eof_in) begin
            if (!slot_count_select_reg && slot_index_reg != `TACR_LAST_SLOT) begin
              slot_index_reg <= slot_index_reg + 4'h1;
              state_reg <= TACR_WAIT;
            end else begin
              state_reg <= TACR_IDLE;
            end
          end
        end
        default: state_reg <= TACR_IDLE;
      endcase
    end
  end

  // Reply strobe one cycle when a slot opens and the UID matches
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      reply_out <= 1'b0;
      slot_index_out <= 4'h0;
      active_out <= 1'b0;
    end else begin
      reply_out <= (state_reg == TACR_WAIT) && timer_done && !sof_in && match;
      slot_index_out <= slot_index_reg;
      active_out <= (state_reg != TACR_IDLE);
    end
  end

  // Checker helpers only; the delay block is checked against a count of its own
  for (genvar b = 0; b < 64; b++) begin : g_mask_keep
    assign mask_keep[b] = (7'(b) < mask_bits_reg);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wait_cycles_reg <= 24'h00_0000;
    end else if (state_reg == TACR_WAIT) begin
      wait_cycles_reg <= wait_cycles_reg + 24'h00_0001;
    end else begin
      wait_cycles_reg <= 24'h00_0000;
    end
  end

  chk_header_zero_bits: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    header_out.flags[7:1] == 7'h00) else $error("reserved flag bits set");
  chk_error_code_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    header_out.error_present == header_out.flags[0]) else $error("error code presence mismatch");
  chk_error_code_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    header_out.error_present |-> header_out.error_code inside {8'h03, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14})
    else $error("reserved error code");
  chk_option_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cause_valid_in && cause_in == TACR_ERR_OPTION_CAUSE |=> header_out.error_code == 8'h03)
    else $error("bad option code");
  chk_prog_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cause_valid_in && cause_in == TACR_ERR_PROG_CAUSE |=> header_out.error_code == 8'h13)
    else $error("bad program code");
  chk_locked_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cause_valid_in && cause_in == TACR_ERR_LOCKED_CAUSE |=> header_out.error_code == 8'h12)
    else $error("bad locked code");
  chk_error_bit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cause_valid_in |=> header_out.flags[0] == ($past(cause_in) != TACR_ERR_NONE_CAUSE))
    else $error("error bit wrong");
  chk_sof_abort: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sof_in |=> state_reg == TACR_IDLE) else $error("sequence not aborted");
  chk_restart_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_IDLE && inventory_ok |=> slot_index_reg == 4'h0) else $error("slot not restarted");
  chk_single_slot: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    slot_count_select_reg |-> slot_index_reg == 4'h0) else $error("single slot advanced");
  chk_initiated_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_IDLE && req_valid_in && req_in.command == 8'hD1 && !initiated_out |=> state_reg == TACR_IDLE)
    else $error("uninitiated tag answered");
  chk_error_silent: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_IDLE && req_valid_in && req_error_in |=> state_reg == TACR_IDLE)
    else $error("erroneous request ran");
  chk_reply_delay: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    reply_out |-> $past(state_reg) == TACR_WAIT) else $error("reply without delay");

  // Error header checks
  chk_absent_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cause_valid_in && cause_in == TACR_ERR_BLOCK_NA_CAUSE |=> header_out.error_code == 8'h10)
    else $error("bad absent block code");
  chk_relock_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cause_valid_in && cause_in == TACR_ERR_RELOCK_CAUSE |=> header_out.error_code == 8'h11)
    else $error("bad relock code");
  chk_lockfail_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cause_valid_in && cause_in == TACR_ERR_LOCKFAIL_CAUSE |=> header_out.error_code == 8'h14)
    else $error("bad lock failure code");
  chk_generic_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cause_valid_in && cause_in == TACR_ERR_OTHER_CAUSE |=> header_out.error_code == 8'h0F)
    else $error("bad generic code");
  chk_no_error_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cause_valid_in && cause_in == TACR_ERR_NONE_CAUSE |=> !header_out.error_present)
    else $error("error code present without error");
  chk_header_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !cause_valid_in |=> $stable(header_out))
    else $error("header changed without load");

  // Slot sequencing checks
  chk_inventory_start: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    inventory_ok |=> state_reg == TACR_WAIT)
    else $error("inventory not started");
  chk_slot_advance: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_SLOT && eof_in && !sof_in && !slot_count_select_reg && slot_index_reg != `TACR_LAST_SLOT
    |=> state_reg == TACR_WAIT && slot_index_reg == $past(slot_index_reg) + 4'h1)
    else $error("slot did not advance");
  chk_last_slot_end: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_SLOT && eof_in && !sof_in && (slot_count_select_reg || slot_index_reg == `TACR_LAST_SLOT)
    |=> state_reg == TACR_IDLE)
    else $error("sequence ran past last slot");
  chk_slot_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_WAIT |=> $stable(slot_index_reg))
    else $error("slot index moved while waiting");
  chk_width_select: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    inventory_ok && req_in.flags[`TACR_FLAG_SLOTSEL] |=> slot_index_width == 7'h00)
    else $error("single slot still indexed");
  chk_delay_length: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_WAIT && timer_done |-> wait_cycles_reg == T1_CYCLES[23:0])
    else $error("response delay length wrong");
  chk_timer_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    timer_done |-> state_reg == TACR_WAIT)
    else $error("delay ended outside a wait");
  chk_reply_timing: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    reply_out |-> $past(wait_cycles_reg) == T1_CYCLES[23:0])
    else $error("reply at wrong time");
  chk_reply_once: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    reply_out |=> !reply_out)
    else $error("reply longer than one cycle");
  chk_reply_active: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    reply_out |-> active_out)
    else $error("reply outside a sequence");

  // Request gating checks
  chk_mask_padding: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (mask_reg & ~mask_keep) == 64'h0000_0000_0000_0000)
    else $error("mask padding not cleared");
  chk_mask_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    inventory_ok |=> mask_bits_reg == $past(req_in.mask_len[6:0]))
    else $error("mask length not loaded");
  chk_request_ignored: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg != TACR_IDLE |=> $stable(mask_reg) && $stable(mask_bits_reg) && $stable(slot_count_select_reg))
    else $error("request taken while running");
  chk_oversize_mask: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_IDLE && req_valid_in && req_in.mask_len > 8'h40 |=> state_reg == TACR_IDLE)
    else $error("oversize mask accepted");
  chk_refused_command: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_IDLE && req_valid_in && !is_inventory |=> state_reg == TACR_IDLE)
    else $error("non-inventory command ran");
  chk_fast_variant_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == TACR_IDLE && req_valid_in && req_in.command == 8'hC1 && !initiated_out |=> state_reg == TACR_IDLE)
    else $error("uninitiated tag answered fast");
  chk_initiated_keep: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    initiated_out |=> initiated_out)
    else $error("initiated bit lost");
  chk_initiate_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_valid_in && !req_error_in && (req_in.command == 8'hD2 || req_in.command == 8'hC2) |=> initiated_out)
    else $error("initiate not recorded");
  chk_fast_rate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req_valid_in && !req_error_in
    |=> fast_rate_out == ($past(req_in.command) == 8'hC2 || $past(req_in.command) == 8'hC1))
    else $error("response rate wrong");
endmodule : tacr_core

// >>> rtl/tacr_delay.sv
`timescale 1ns/1ps
`include "tacr_params.svh"

module tacr_delay #(
  parameter int unsigned CYCLES = `TACR_T1_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic abort_in,
  output logic done_out
);
  logic [23:0] count_reg;
  logic busy_reg;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= 24'h00_0000;
      busy_reg <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        busy_reg <= 1'b0;
      end else if (start_in) begin
        busy_reg <= 1'b1;
        count_reg <= 24'h00_0001;
      end else if (busy_reg) begin
        if (count_reg >= CYCLES[23:0]) begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count_reg <= count_reg + 24'h00_0001;
        end
      end
    end
  end
endmodule : tacr_delay

// >>> tb/tacr_core_tb.sv
`timescale 1ns/1ps
`include "tacr_params.svh"

module tacr_core_tb;
  import tacr_pkg::*;
  localparam int unsigned T1 = 10;
  localparam logic [63:0] UID_VAL = 64'h1122_3344_5566_A4CF;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid_in, req_error_in, sof_in, eof_in;
  logic cause_valid_in = 1'b0;
  tacr_request_type req_in;
  tacr_cause_type cause_in = TACR_ERR_NONE_CAUSE;
  tacr_header_type header_out;
  logic reply_out, active_out, initiated_out, fast_rate_out;
  logic [3:0] slot_index_out;
  logic [7:0] codes [8] = '{8'h00, `TACR_ERR_OPTION, `TACR_ERR_BLK_NA, `TACR_ERR_BLK_RELOCK,
                            `TACR_ERR_BLK_LOCKED, `TACR_ERR_PROG_FAIL, `TACR_ERR_LOCK_FAIL, `TACR_ERR_GENERIC};
  int err_total = 0;
  int check_count = 0;
  int hits;
  int first;
  always #20 clk_sys_in = ~clk_sys_in;
  tacr_reader_model i_tacr_reader_model (.clk_sys_in(clk_sys_in), .req_valid_out(req_valid_in),
    .req_out(req_in), .req_error_out(req_error_in), .sof_out(sof_in), .eof_out(eof_in));
  tacr_core #(.T1_CYCLES(T1), .UID(UID_VAL)) i_tacr_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .req_error_in(req_error_in), .sof_in(sof_in),
    .eof_in(eof_in), .cause_in(cause_in), .cause_valid_in(cause_valid_in), .header_out(header_out),
    .reply_out(reply_out), .slot_index_out(slot_index_out), .active_out(active_out),
    .initiated_out(initiated_out), .fast_rate_out(fast_rate_out));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // Counts reply pulses over one slot; window is twice the delay
  task automatic watch_slot(input logic exp, input logic [3:0] idx);
    hits = 0;
    first = 0;
    for (int i = 1; i <= 2 * T1; i++) begin
      @(negedge clk_sys_in);
      if (reply_out === 1'b1) begin
        hits++;
        if (first == 0) first = i;
      end
    end
    chk("reply count", {63'h0, exp}, 64'(hits));
    if (exp) chk("reply delay", 64'(T1 + 1), 64'(first));
    chk("slot index", {60'h0, idx}, {60'h0, slot_index_out});
  endtask : watch_slot
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    err_total++;
    $display("unexpected timeout: expected end seen hang");
    final_report();
  end
  initial begin
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    chk("reset outputs", 64'h0, 64'({header_out, reply_out, active_out, initiated_out, fast_rate_out}));
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_sys_in);
      cause_in = tacr_cause_type'(k[2:0]);
      cause_valid_in = 1'b1;
      @(negedge clk_sys_in);
      cause_valid_in = 1'b0;
      @(negedge clk_sys_in);
      chk("flag byte", {56'h0, 7'h0, k != 0}, {56'h0, header_out.flags});
      chk("error present", {63'h0, k != 0}, {63'h0, header_out.error_present});
      if (k != 0) chk("error code", {56'h0, codes[k]}, {56'h0, header_out.error_code});
    end
    // 11-bit mask, slot bits of the identifier give 4
    i_tacr_reader_model.send_req(8'h04, `TACR_CMD_INVENTORY, 8'h0B, UID_VAL, 1'b0);
    for (int s = 0; s < 17; s++) begin
      if (s > 0) i_tacr_reader_model.pulse_eof();
      watch_slot(s == 4, (s > 15) ? 4'hF : 4'(s));
    end
    chk("sequence end", 64'h0, {63'h0, active_out});
    i_tacr_reader_model.send_req(8'h04, `TACR_CMD_INVENTORY, 8'h0B, UID_VAL, 1'b0);
    watch_slot(1'b0, 4'h0);
    i_tacr_reader_model.pulse_eof();
    watch_slot(1'b0, 4'h1);
    chk("active", 64'h1, {63'h0, active_out});
    i_tacr_reader_model.pulse_sof();
    @(negedge clk_sys_in);
    chk("aborted", 64'h0, {63'h0, active_out});
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INVENTORY, 8'h0B, UID_VAL, 1'b0);
    watch_slot(1'b1, 4'h0);
    i_tacr_reader_model.pulse_sof();
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INVENTORY, 8'h0B, ~UID_VAL, 1'b0);
    watch_slot(1'b0, 4'h0);
    i_tacr_reader_model.pulse_sof();
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INVENTORY, 8'h00, UID_VAL, 1'b1);
    watch_slot(1'b0, 4'h0);
    chk("silent on error", 64'h0, {63'h0, active_out});
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INVENTORY, 8'h48, UID_VAL, 1'b0);
    watch_slot(1'b0, 4'h0);
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INV_INIT, 8'h00, UID_VAL, 1'b0);
    watch_slot(1'b0, 4'h0);
    chk("initiated", 64'h0, {63'h0, initiated_out});
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_FAST_INV_INIT, 8'h00, UID_VAL, 1'b0);
    watch_slot(1'b0, 4'h0);
    i_tacr_reader_model.pulse_sof();
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INITIATE, 8'h00, UID_VAL, 1'b0);
    repeat (2 * T1) @(negedge clk_sys_in);
    chk("initiated", 64'h1, {63'h0, initiated_out});
    i_tacr_reader_model.pulse_sof();
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INV_INIT, 8'h00, UID_VAL, 1'b0);
    watch_slot(1'b1, 4'h0);
    i_tacr_reader_model.pulse_sof();
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_FAST_INV_INIT, 8'h00, UID_VAL, 1'b0);
    watch_slot(1'b1, 4'h0);
    chk("fast rate", 64'h1, {63'h0, fast_rate_out});
    i_tacr_reader_model.pulse_sof();
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INVENTORY, 8'h00, UID_VAL, 1'b0);
    watch_slot(1'b1, 4'h0);
    chk("normal rate", 64'h0, {63'h0, fast_rate_out});
    i_tacr_reader_model.pulse_sof();
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_FAST_INITIATE, 8'h00, UID_VAL, 1'b0);
    repeat (2 * T1) @(negedge clk_sys_in);
    chk("fast rate", 64'h1, {63'h0, fast_rate_out});
    // Reset in mid-sequence clears everything, the initiated bit too
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INVENTORY, 8'h00, UID_VAL, 1'b0);
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    chk("reset mid run", 64'h0, 64'({header_out, reply_out, active_out, initiated_out, fast_rate_out}));
    i_tacr_reader_model.send_req(8'h24, `TACR_CMD_INV_INIT, 8'h00, UID_VAL, 1'b0);
    watch_slot(1'b0, 4'h0);
    final_report();
  end
endmodule : tacr_core_tb

// >>> tb/tacr_reader_model.sv
`timescale 1ns/1ps

module tacr_reader_model (
  input wire logic clk_sys_in,
  output logic req_valid_out,
  output tacr_pkg::tacr_request_type req_out,
  output logic req_error_out,
  output logic sof_out,
  output logic eof_out
);
  import tacr_pkg::*;
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
    req_error_out = 1'b0;
    sof_out = 1'b0;
    eof_out = 1'b0;
  end
  // Request fields, mask padded with zeros above its length
  task automatic send_req(input logic [7:0] flg, input logic [7:0] cmd, input logic [7:0] len,
                          input logic [63:0] mask, input logic err);
    logic [63:0] keep;
    keep = (len >= 8'h40) ? 64'hFFFF_FFFF_FFFF_FFFF : ((64'h1 << len) - 64'h1);
    @(negedge clk_sys_in);
    req_out = {flg, cmd, 8'h00, len, mask & keep};
    req_error_out = err;
    req_valid_out = 1'b1;
    @(negedge clk_sys_in);
    req_valid_out = 1'b0;
    req_error_out = 1'b0;
    // Released fields must not look valid
    req_out = ~req_out;
  endtask : send_req
  task automatic pulse_eof();
    @(negedge clk_sys_in);
    eof_out = 1'b1;
    @(negedge clk_sys_in);
    eof_out = 1'b0;
  endtask : pulse_eof
  task automatic pulse_sof();
    @(negedge clk_sys_in);
    sof_out = 1'b1;
    @(negedge clk_sys_in);
    sof_out = 1'b0;
  endtask : pulse_sof
endmodule : tacr_reader_model
